// File: design/async_serial_transmitter.sv
// Asynchronous serial transmitter with a one-deep holding buffer, shift
// register, 8/16-bit baud generator and APB register access.
// Assumes one core clock at 20 MHz, synchronous active-high reset, and a
// receiver elsewhere that shares the baud tick and the format bits.
//
// Contract
// - Frame: start space, 8/9 data, stop mark
// - NRZ, mark is one, idle at mark
// - Every bit lasts exactly one baud period
// - Data leaves least significant bit first
// - Shared format and rate, no parity hardware
// - Baud from core clock, 8/16-bit divider
// - Transmit only with enable, async, port on
// - Port enabled drives pin regardless of direction; here only with transmit enable on and sync mode off too
// - Disabled transmitter releases pin to general use
// - Holding write starts; empty shifter loads at once
// - Busy shifter: load after stop, start follows
// - Invert bit flips idle and data levels
// - Buffer-empty flag set unless character is queued
// - Flag valid second cycle after holding write
// - Buffer-empty flag is read-only to software
// - Enabling transmitter sets buffer-empty flag
// - Flag ignores enables; request needs all three
// - Read-only shift-empty bit, no interrupt
// - Nine-bit mode sends ninth bit as MSB
// - Ninth bit one marks an address character
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps

module async_serial_transmitter (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // APB slave
  input  wire async_tx_pkg::apb_req_t  apbReq,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // General purpose use of the pin while the transmitter is off
  input  wire logic                    gpioOut,
  input  wire logic                    gpioOe,
  // Transmit pin
  output logic                         txPinOut,
  output logic                         txPinOe,
  // Shared with receiver and interrupt controller
  output logic                         baudTick,
  output logic                         nineBitFormat,
  output logic                         portEnabled,
  output logic                         txIrq
);

  async_tx_pkg::tx_state_t state;
  async_tx_pkg::tx_state_t next_state;

  logic        txOn;
  logic        accessWrite;
  logic        setupRead;
  logic        addrKnown;
  logic        holdWrite;
  logic [21:0] bitPeriod;
  logic        tick;

  // Bit period in core cycles: prescale times (divisor + 1)
  function automatic logic [21:0] period_cycles(input logic [15:0] div,
                                                input logic        wide,
                                                input logic        fast);
    logic [6:0]  pre;
    logic [16:0] span;
    pre  = async_tx_pkg::PRESCALE_SLOW;
    span = 17'h00000;
    if (wide && fast) begin
      pre = async_tx_pkg::PRESCALE_FAST;
    end else if (wide || fast) begin
      pre = async_tx_pkg::PRESCALE_MID;
    end
    if (wide) begin
      span = {1'b0, div} + 17'h00001;
    end else begin
      span = {9'h000, div[7:0]} + 17'h00001;
    end
    return 22'(span * pre);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    return (addr == async_tx_pkg::ADDR_CONTROL) || (addr == async_tx_pkg::ADDR_DIVISOR)
        || (addr == async_tx_pkg::ADDR_HOLDING) || (addr == async_tx_pkg::ADDR_STATUS);
  endfunction

  always_comb begin
    txOn = state.control[async_tx_pkg::CTL_TX_ENABLE]
         && !state.control[async_tx_pkg::CTL_SYNC_MODE]
         && state.control[async_tx_pkg::CTL_PORT_ENABLE];
    addrKnown   = addr_mapped(apbReq.paddr);
    accessWrite = apbReq.psel && apbReq.penable && apbReq.pwrite && addrKnown;
    setupRead   = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    // A full holding register refuses further characters
    holdWrite   = accessWrite && (apbReq.paddr == async_tx_pkg::ADDR_HOLDING)
                && txOn && !state.holdFull;
    bitPeriod   = period_cycles(state.divisor,
                                state.control[async_tx_pkg::CTL_WIDE_DIV],
                                state.control[async_tx_pkg::CTL_HIGH_SPEED]);
    // Free-running between frames so the receiver side sees a steady
    // tick; a new frame restarts it from zero
    tick        = (state.baudCount >= bitPeriod - 22'h000001);
  end

  always_comb begin
    logic       haveChar;
    logic [8:0] charData;
    next_state = state;
    haveChar   = state.holdFull;
    charData   = state.holdData;

    // Register writes; status is read-only so the flag cannot be forced
    if (accessWrite) begin
      case (apbReq.paddr)
        async_tx_pkg::ADDR_CONTROL: begin
          next_state.control = apbReq.pwdata[async_tx_pkg::CTL_WIDTH-1:0];
        end
        async_tx_pkg::ADDR_DIVISOR: begin
          next_state.divisor = apbReq.pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    if (holdWrite) begin
      haveChar = 1'b1;
      charData = {state.control[async_tx_pkg::CTL_NINTH_BIT], apbReq.pwdata[7:0]};
    end

    // Baud counter; restarted on a fresh frame so the start bit is whole
    if (tick) begin
      next_state.baudCount = 22'h000000;
    end else begin
      next_state.baudCount = state.baudCount + 22'h000001;
    end

    case (state.fsm)
      async_tx_pkg::TX_IDLE: begin
        next_state.lineBit = 1'b1;
        if (haveChar) begin
          next_state.fsm       = async_tx_pkg::TX_START;
          next_state.shiftData = charData;
          next_state.baudCount = 22'h000000;
          next_state.lineBit   = 1'b0;
          haveChar             = 1'b0;
        end
      end
      async_tx_pkg::TX_START: begin
        if (tick) begin
          next_state.fsm       = async_tx_pkg::TX_DATA;
          next_state.lineBit   = state.shiftData[0];
          next_state.shiftData = {1'b0, state.shiftData[8:1]};
          next_state.bitCount  = 4'h1;
        end
      end
      async_tx_pkg::TX_DATA: begin
        if (tick) begin
          if (state.bitCount == (state.control[async_tx_pkg::CTL_NINE_BIT]
                                 ? async_tx_pkg::BITS_NINE : async_tx_pkg::BITS_EIGHT)) begin
            next_state.fsm     = async_tx_pkg::TX_STOP;
            next_state.lineBit = 1'b1;
          end else begin
            next_state.lineBit   = state.shiftData[0];
            next_state.shiftData = {1'b0, state.shiftData[8:1]};
            next_state.bitCount  = state.bitCount + 4'h1;
          end
        end
      end
      async_tx_pkg::TX_STOP: begin
        if (tick) begin
          if (haveChar) begin
            next_state.fsm       = async_tx_pkg::TX_START;
            next_state.shiftData = charData;
            next_state.lineBit   = 1'b0;
            haveChar             = 1'b0;
          end else begin
            next_state.fsm = async_tx_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_state.fsm = async_tx_pkg::TX_IDLE;
      end
    endcase

    next_state.holdFull = haveChar;
    next_state.holdData = charData;

    // Dropping any enable abandons the frame and empties the buffer
    if (!txOn) begin
      next_state.fsm      = async_tx_pkg::TX_IDLE;
      next_state.holdFull = 1'b0;
      next_state.lineBit  = 1'b1;
    end

    // Flag lags a holding write by the register stage below
    next_state.bufEmptyFlag = txOn && !state.holdFull;

    if (setupRead) begin
      next_state.readData = 32'h00000000;
      case (apbReq.paddr)
        async_tx_pkg::ADDR_CONTROL: begin
          next_state.readData[async_tx_pkg::CTL_WIDTH-1:0] = state.control;
        end
        async_tx_pkg::ADDR_DIVISOR: begin
          next_state.readData[15:0] = state.divisor;
        end
        async_tx_pkg::ADDR_STATUS: begin
          next_state.readData[async_tx_pkg::STS_BUF_EMPTY]   = state.bufEmptyFlag;
          next_state.readData[async_tx_pkg::STS_SHIFT_EMPTY] =
            (state.fsm == async_tx_pkg::TX_IDLE);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state.control      <= async_tx_pkg::CONTROL_RESET;
      state.divisor      <= async_tx_pkg::DIVISOR_RESET;
      state.readData     <= 32'h00000000;
      state.fsm          <= async_tx_pkg::TX_IDLE;
      state.holdData     <= 9'h000;
      state.holdFull     <= 1'b0;
      state.shiftData    <= 9'h000;
      state.bitCount     <= 4'h0;
      state.baudCount    <= 22'h000000;
      state.bufEmptyFlag <= 1'b0;
      state.lineBit      <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    prdata        = state.readData;
    pready        = 1'b1;
    pslverr       = apbReq.psel && apbReq.penable && !addrKnown;
    // Invert acts only in asynchronous mode
    txPinOut      = txOn ? (state.lineBit ^ state.control[async_tx_pkg::CTL_INVERT])
                         : gpioOut;
    txPinOe       = txOn ? 1'b1 : gpioOe;
    baudTick      = tick;
    nineBitFormat = state.control[async_tx_pkg::CTL_NINE_BIT];
    portEnabled   = state.control[async_tx_pkg::CTL_PORT_ENABLE];
    txIrq         = state.bufEmptyFlag
                  && state.control[async_tx_pkg::CTL_IRQ_ENABLE]
                  && state.control[async_tx_pkg::CTL_GLOBAL_IRQ]
                  && state.control[async_tx_pkg::CTL_PERIPH_IRQ];
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_idle_mark: assert property (
    txOn && state.fsm == async_tx_pkg::TX_IDLE && !$past(state.fsm == async_tx_pkg::TX_STOP)
    |-> txPinOut == !state.control[async_tx_pkg::CTL_INVERT])
    else $error("idle line not at mark");

  a_start_space: assert property (
    state.fsm == async_tx_pkg::TX_START |-> state.lineBit == 1'b0)
    else $error("start bit not space");

  a_stop_mark: assert property (
    state.fsm == async_tx_pkg::TX_STOP |-> state.lineBit == 1'b1)
    else $error("stop bit not mark");

  a_bit_hold: assert property (
    $changed(state.lineBit) && $past(state.fsm) != async_tx_pkg::TX_IDLE && $past(txOn)
    |-> $past(tick))
    else $error("line changed inside a bit period");

  a_load_ninth: assert property (
    holdWrite && state.fsm == async_tx_pkg::TX_IDLE
    |=> state.fsm == async_tx_pkg::TX_START
        && state.shiftData[8] == $past(state.control[async_tx_pkg::CTL_NINTH_BIT]))
    else $error("character not loaded with ninth bit");

  a_flag_delay: assert property (
    holdWrite && state.fsm != async_tx_pkg::TX_IDLE && !tick && bitPeriod > 22'h000002
    |-> state.bufEmptyFlag ##1 state.holdFull ##1 !state.bufEmptyFlag)
    else $error("buffer-empty flag timing wrong");

  a_flag_state: assert property (
    $past(txOn) && txOn |-> state.bufEmptyFlag == !$past(state.holdFull))
    else $error("buffer-empty flag disagrees with holding register");

  a_pin_drive: assert property (
    txOn |-> txPinOe && txPinOut == (state.lineBit ^ state.control[async_tx_pkg::CTL_INVERT]))
    else $error("pin not driven by transmitter");

  a_pin_release: assert property (
    !txOn |-> txPinOe == gpioOe && txPinOut == gpioOut)
    else $error("pin not released");

  a_irq_gate: assert property (
    txIrq |-> state.bufEmptyFlag && state.control[async_tx_pkg::CTL_IRQ_ENABLE]
              && state.control[async_tx_pkg::CTL_GLOBAL_IRQ]
              && state.control[async_tx_pkg::CTL_PERIPH_IRQ])
    else $error("interrupt without flag and enable");

  a_irq_raise: assert property (
    state.bufEmptyFlag && state.control[async_tx_pkg::CTL_IRQ_ENABLE]
    && state.control[async_tx_pkg::CTL_GLOBAL_IRQ] && state.control[async_tx_pkg::CTL_PERIPH_IRQ]
    |-> txIrq)
    else $error("interrupt missing with flag and all enables");

  // A cleared flag must mean a busy shifter with a character waiting
  a_flag_busy: assert property (
    txOn && $past(txOn) && !state.bufEmptyFlag
    |-> $past(state.holdFull) && $past(state.fsm != async_tx_pkg::TX_IDLE))
    else $error("buffer-empty flag clear without queued character");

  a_flag_on: assert property (
    $rose(txOn) |=> state.bufEmptyFlag)
    else $error("buffer-empty flag not set on enable");

  // Software may still see the flag set right after its write
  a_flag_hold: assert property (
    holdWrite |=> state.bufEmptyFlag)
    else $error("buffer-empty flag cleared at once");

  a_queue_load: assert property (
    txOn && state.fsm == async_tx_pkg::TX_STOP && tick && state.holdFull
    |=> state.fsm == async_tx_pkg::TX_START && !state.holdFull && !state.lineBit
        && state.shiftData == $past(state.holdData))
    else $error("queued character not loaded after stop");

  // A write to a full buffer is dropped, not merged into the queued one
  a_hold_keep: assert property (
    txOn && accessWrite && apbReq.paddr == async_tx_pkg::ADDR_HOLDING && state.holdFull
    && !(state.fsm == async_tx_pkg::TX_STOP && tick)
    |=> state.holdFull && state.holdData == $past(state.holdData))
    else $error("queued character overwritten");

  a_eight_stop: assert property (
    txOn && state.fsm == async_tx_pkg::TX_DATA && tick
    && state.bitCount == async_tx_pkg::BITS_EIGHT && !state.control[async_tx_pkg::CTL_NINE_BIT]
    |=> state.fsm == async_tx_pkg::TX_STOP)
    else $error("stop bit not after eighth data bit");

  a_nine_more: assert property (
    txOn && state.fsm == async_tx_pkg::TX_DATA && tick
    && state.bitCount == async_tx_pkg::BITS_EIGHT && state.control[async_tx_pkg::CTL_NINE_BIT]
    |=> state.fsm == async_tx_pkg::TX_DATA && state.lineBit == $past(state.shiftData[0]))
    else $error("ninth data bit not sent");

  a_off_idle: assert property (
    !txOn |=> state.fsm == async_tx_pkg::TX_IDLE && !state.holdFull && state.lineBit)
    else $error("transmitter busy while disabled");

  // Status is a snapshot taken at the setup edge
  a_shift_status: assert property (
    setupRead && apbReq.paddr == async_tx_pkg::ADDR_STATUS
    |=> prdata[async_tx_pkg::STS_SHIFT_EMPTY] == $past(state.fsm == async_tx_pkg::TX_IDLE))
    else $error("shift-empty status wrong");

  c_frame_done: cover property (
    state.fsm == async_tx_pkg::TX_STOP ##1 state.fsm == async_tx_pkg::TX_IDLE);
  c_back_to_back: cover property (
    state.fsm == async_tx_pkg::TX_STOP && tick && state.holdFull);
  c_nine_bit: cover property (
    state.fsm == async_tx_pkg::TX_DATA && state.bitCount == async_tx_pkg::BITS_NINE);
  c_inverted: cover property (
    txOn && state.control[async_tx_pkg::CTL_INVERT] && state.fsm == async_tx_pkg::TX_START);
  c_abort: cover property (
    state.fsm != async_tx_pkg::TX_IDLE && !txOn);

endmodule

// File: design/async_tx_pkg.sv
// Package for the asynchronous serial transmitter: register map, field
// positions, reset values, baud prescale figures and the state record.
// Assumes a 20 MHz core clock and an APB master with 32-bit data.
package async_tx_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DIVISOR = 8'h04;
  localparam logic [7:0] ADDR_HOLDING = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;

  // Control register field positions
  localparam int CTL_TX_ENABLE   = 0;
  localparam int CTL_SYNC_MODE   = 1;
  localparam int CTL_PORT_ENABLE = 2;
  localparam int CTL_NINE_BIT    = 3;
  localparam int CTL_INVERT      = 4;
  localparam int CTL_WIDE_DIV    = 5;
  localparam int CTL_HIGH_SPEED  = 6;
  localparam int CTL_NINTH_BIT   = 7;
  localparam int CTL_IRQ_ENABLE  = 8;
  localparam int CTL_GLOBAL_IRQ  = 9;
  localparam int CTL_PERIPH_IRQ  = 10;
  localparam int CTL_WIDTH       = 11;

  // Status register field positions
  localparam int STS_BUF_EMPTY   = 0;
  localparam int STS_SHIFT_EMPTY = 1;

  localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 11'h000;
  localparam logic [15:0]          DIVISOR_RESET = 16'h0000;

  // Baud generator prescale per speed selection
  localparam logic [6:0] PRESCALE_FAST = 7'h04;
  localparam logic [6:0] PRESCALE_MID  = 7'h10;
  localparam logic [6:0] PRESCALE_SLOW = 7'h40;

  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [CTL_WIDTH-1:0] control;
    logic [15:0]          divisor;
    logic [31:0]          readData;
    tx_fsm_t              fsm;
    logic [8:0]           holdData;
    logic                 holdFull;
    logic [8:0]           shiftData;
    logic [3:0]           bitCount;
    logic [21:0]          baudCount;
    logic                 bufEmptyFlag;
    logic                 lineBit;
  } tx_state_t;

endpackage

// File: test/serial_line_monitor.sv
// Far-end receiver model that watches the transmit pin and rebuilds characters.
// Assumes the bench supplies the bit period in core clock cycles and the format bits.
`timescale 1ns/10ps

module serial_line_monitor (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Observed line and the format that the bench expects
  input  wire logic        line,
  input  wire logic        invert,
  input  wire logic        nine,
  input  wire logic [15:0] bitPeriod,
  // Received results
  output logic      [8:0]  rxData,
  output logic             frameErr,
  output logic      [7:0]  rxCount,
  output logic      [31:0] lastStart,
  output logic      [31:0] prevStart
);
  logic [31:0] cyc;
  logic [31:0] startAt;
  logic [8:0]  shiftIn;

  always @(posedge core_clk) begin
    if (reset) begin
      cyc <= 32'h0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  // Start is sampled again at mid bit, so a short glitch is not taken as a frame
  initial begin
    rxData = 9'h000;
    frameErr = 1'b0;
    rxCount = 8'h00;
    lastStart = 32'h0;
    prevStart = 32'h0;
    forever begin
      @(posedge core_clk);
      if (!reset && (line ^ invert) == 1'b0) begin
        startAt = cyc;
        repeat (bitPeriod / 2) @(posedge core_clk);
        if ((line ^ invert) == 1'b0) begin
          shiftIn = 9'h000;
          for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bitPeriod) @(posedge core_clk);
            shiftIn[i] = line ^ invert;
          end
          repeat (bitPeriod) @(posedge core_clk);
          frameErr = !(line ^ invert);
          rxData = shiftIn;
          prevStart = lastStart;
          lastStart = startAt;
          rxCount = rxCount + 8'h01;
        end
      end
    end
  end
endmodule

// File: test/async_serial_transmitter_tb_top.sv
// Self-checking bench: APB register access, framing, queueing and pin hand-over.
// Assumes the far-end monitor model and zero-wait-state APB answers.
`timescale 1ns/10ps

module async_serial_transmitter_tb_top;
  logic                   core_clk;
  logic                   reset;
  logic                   gpioOut;
  logic                   gpioOe;
  async_tx_pkg::apb_req_t apbReq;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   txPinOut;
  logic                   txPinOe;
  logic                   baudTick;
  logic                   nineBitFormat;
  logic                   portEnabled;
  logic                   txIrq;
  logic                   monInvert;
  logic                   monNine;
  logic [15:0]            monPeriod;
  logic [8:0]             rxData;
  logic                   frameErr;
  logic [7:0]             rxCount;
  logic [31:0]            lastStart;
  logic [31:0]            prevStart;
  logic [31:0]            rd;
  logic                   err;
  int                     n_fail;
  int                     tests_run;
  int                     ticks;

  localparam logic [7:0] CTL = async_tx_pkg::ADDR_CONTROL;
  localparam logic [7:0] DIV = async_tx_pkg::ADDR_DIVISOR;
  localparam logic [7:0] HLD = async_tx_pkg::ADDR_HOLDING;
  localparam logic [7:0] STS = async_tx_pkg::ADDR_STATUS;

  async_serial_transmitter u_dut (
    .core_clk(core_clk), .reset(reset), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .baudTick(baudTick),
    .nineBitFormat(nineBitFormat), .portEnabled(portEnabled), .txIrq(txIrq)
  );

  serial_line_monitor u_mon (
    .core_clk(core_clk), .reset(reset), .line(txPinOut), .invert(monInvert),
    .nine(monNine), .bitPeriod(monPeriod), .rxData(rxData), .frameErr(frameErr),
    .rxCount(rxCount), .lastStart(lastStart), .prevStart(prevStart)
  );

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task rxchk(input logic [7:0] k, input logic [9:0] exp);
    int n;
    n = 0;
    while (rxCount != k && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 6000) begin
      n_fail++;
      stop_test;
    end
    chk({frameErr, rxData}, exp);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    gpioOut = 1'b1;
    gpioOe = 1'b0;
    apbReq = '0;
    monInvert = 1'b0;
    monNine = 1'b0;
    monPeriod = 16'h0008;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(CTL, 32'h0);
    rdchk(DIV, 32'h0);
    rdchk(STS, 32'h2);
    gpioOut <= 1'b0;
    gpioOe <= 1'b1;
    @(posedge core_clk);
    chk({txPinOe, txPinOut}, 32'h2);
    gpioOut <= 1'b1;
    gpioOe <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 32'h1);
    wr(HLD, 32'h77);
    wr(DIV, 32'h1);
    wr(CTL, 32'h64);
    rdchk(STS, 32'h2);
    wr(CTL, 32'h65);
    rdchk(STS, 32'h3);
    chk({txPinOe, txPinOut, portEnabled, nineBitFormat}, 32'hE);
    wr(HLD, 32'hA5);
    wr(HLD, 32'h3C);
    wr(HLD, 32'h99);
    rdchk(STS, 32'h0);
    rxchk(8'h01, 10'h0A5);
    rxchk(8'h02, 10'h03C);
    chk(lastStart - prevStart, 32'd80);
    // The monitor samples mid stop bit; let the shifter finish it
    repeat (monPeriod) @(posedge core_clk);
    rdchk(STS, 32'h3);
    wr(STS, 32'h0);
    rdchk(STS, 32'h3);
    // Idle line: the baud generator free-runs, one tick per period of 8
    ticks = 0;
    repeat (16) begin
      @(posedge core_clk);
      ticks += baudTick;
    end
    chk(ticks, 32'h2);
    wr(CTL, 32'h165);
    @(posedge core_clk);
    chk(txIrq, 32'h0);
    wr(CTL, 32'h7ED);
    monNine <= 1'b1;
    @(posedge core_clk);
    chk({txIrq, nineBitFormat}, 32'h3);
    wr(HLD, 32'h55);
    wr(CTL, 32'h6ED);
    wr(HLD, 32'h00);
    rdchk(STS, 32'h0);
    rxchk(8'h03, 10'h155);
    rxchk(8'h04, 10'h100);
    wr(CTL, 32'h75);
    monNine <= 1'b0;
    monInvert <= 1'b1;
    @(posedge core_clk);
    chk(txPinOut, 32'h0);
    wr(HLD, 32'hC3);
    rxchk(8'h05, 10'h0C3);
    wr(DIV, 32'h100);
    wr(CTL, 32'h45);
    monInvert <= 1'b0;
    monPeriod <= 16'h0010;
    wr(HLD, 32'h81);
    rxchk(8'h06, 10'h081);
    wr(CTL, 32'h47);
    @(posedge core_clk);
    chk({txPinOe, txPinOut}, 32'h1);
    wr(HLD, 32'h12);
    rdchk(STS, 32'h2);
    repeat (400) @(posedge core_clk);
    chk(rxCount, 32'h6);
    stop_test;
  end
endmodule
